// ### touch_scan_mode_controller.sv
// scan sequencer, mode manager and pin output roles of the touch controller
`timescale 1ns/1ps
module touch_scan_mode_controller
	import touch_scan_pkg::*;
#(
	parameter int MS_CYC     = MS_CYCLES,
	parameter int BUZZ_PHASE = BUZZ_PHASE_CYCLES,
	parameter int BUZZ_HALF1 = BUZZ_HALF1_CYCLES,
	parameter int BUZZ_HALF2 = BUZZ_HALF2_CYCLES
) (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 ce,
	input  wire logic [7:0]           sense_enable,
	output logic                      sense_req,
	output logic      [2:0]           sense_idx,
	input  wire logic                 sense_done,
	input  wire logic [COUNT_W-1:0]   sense_count,
	input  wire logic [COUNT_W-1:0]   threshold,
	input  wire logic [COUNT_W-1:0]   hysteresis,
	input  wire logic [15:0]          active_period_ms,
	input  wire logic [15:0]          doze_period_ms,
	input  wire logic [15:0]          passive_ms,
	input  wire logic                 force_valid,
	input  wire logic [1:0]           force_mode,
	input  wire logic                 host_access,
	input  wire logic                 status_read,
	output logic                      host_irq_n,
	output logic      [7:0]           button_status,
	output logic      [7:0]           gpi_status,
	output logic      [2:0]           op_mode,
	output logic      [2:0]           scan_phase,
	output logic                      low_power,
	input  wire logic [15:0]          pin_mode,
	input  wire logic                 auto_light_en,
	input  wire logic [7:0]           host_level,
	input  wire logic [63:0]          direct_width,
	input  wire logic                 fade_log,
	input  wire logic [7:0]           fade_step_ms,
	input  wire logic [7:0]           fade_lo,
	input  wire logic [7:0]           fade_hi,
	input  wire logic [7:0]           level_to_second,
	input  wire logic [63:0]          level_width,
	input  wire logic [7:0]           level_idle,
	input  wire logic                 buzz_en,
	input  wire logic                 buzz_idle,
	input  wire logic [7:0]           gpio_in,
	output logic      [7:0]           gpio_out,
	output logic      [7:0]           gpio_oe
);
	scan_state_e state_reg;
	op_mode_e    mode_reg;

	logic [COUNT_W-1:0] count_mem [NUM_PINS];
	logic [23:0]        ms_cnt_reg;
	logic               ms_tick;
	logic [15:0]        cycle_ms_reg;
	logic [15:0]        idle_ms_reg;
	logic [15:0]        period_ms;
	logic [3:0]         idx_reg;
	logic [3:0]         next_idx;
	logic [7:0]         touch_next;
	logic [7:0]         input_pins;
	logic               irq_pend_reg;
	logic               status_change;
	logic               gpi_wake;
	logic [7:0]         level_reg;
	logic [63:0]        width_reg;
	logic [7:0]         fade_cnt_reg;
	logic               fade_tick;
	logic [7:0]         first_duty_reg;
	logic [7:0]         second_duty_reg;
	logic               buzz_run_reg;
	logic               buzz_phase2_reg;
	logic [23:0]        buzz_cnt_reg;
	logic [15:0]        buzz_half_reg;
	logic               buzz_sq_reg;

	generate
		if (MS_CYC < 1 || MS_CYC > 24'hFFFFFF || BUZZ_PHASE < 1 || BUZZ_PHASE > 24'hFFFFFF
		    || BUZZ_HALF1 < 1 || BUZZ_HALF2 < 1 || BUZZ_HALF1 > 16'hFFFF
		    || BUZZ_HALF2 > 16'hFFFF) begin : g_chk
			$error("touch_scan_mode_controller: timing count out of range");
		end
	endgenerate

	// first enabled sensor at or above a start index, 8 when none is left
	function automatic logic [3:0] find_enabled(input logic [7:0] mask, input logic [3:0] from);
		logic [3:0] r;
		r = 4'h8;
		for (int i = NUM_PINS - 1; i >= 0; i--) begin
			if (mask[i] && 4'(i) >= from) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] pin_role(input logic [15:0] cfg, input int pin);
		return cfg[2*pin +: 2];
	endfunction

	assign next_idx = find_enabled(sense_enable, idx_reg + 4'h1);

	always_comb begin
		period_ms = (mode_reg == MODE_DOZE) ? doze_period_ms : active_period_ms; // R5 R8 R9
		if (period_ms < 16'(SCAN_MIN_MS)) begin
			period_ms = 16'(SCAN_MIN_MS); // R5
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			input_pins[i] = (pin_role(pin_mode, i) == PIN_INPUT);
		end
	end

	// hysteresis band around the threshold keeps transients from chattering
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			touch_next[i] = button_status[i];
			if (!sense_enable[i]) begin
				touch_next[i] = 1'b0;
			end else if (!button_status[i]) begin
				if ({1'b0, count_mem[i]} >= {1'b0, threshold} + {1'b0, hysteresis}) begin
					touch_next[i] = 1'b1; // R23
				end
			end else if ({1'b0, count_mem[i]} + {1'b0, hysteresis} < {1'b0, threshold}) begin
				touch_next[i] = 1'b0; // R23
			end
		end
	end

	assign status_change = (touch_next != button_status)
		|| ((gpio_in & input_pins) != (gpi_status & input_pins));
	assign gpi_wake      = ((gpio_in & input_pins) != (gpi_status & input_pins));

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ms_cnt_reg <= '0;
		end else if (ce) begin
			ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 24'h000001;
		end
	end
	assign ms_tick = (ms_cnt_reg == 24'(MS_CYC - 1));

	// scan sequencer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= ST_START;
			idx_reg   <= 4'h0;
		end else if (ce) begin
			case (state_reg)
				ST_START: begin
					idx_reg   <= find_enabled(sense_enable, 4'h0); // R2
					state_reg <= ST_REQ; // R1
				end
				ST_REQ: begin
					state_reg <= idx_reg[3] ? ST_PROC : ST_WAIT; // R2
				end
				ST_WAIT: begin
					if (sense_done) begin
						idx_reg   <= next_idx; // R2
						state_reg <= ST_REQ;
					end
				end
				ST_PROC: begin
					state_reg <= (mode_reg == MODE_SLEEP) ? ST_SLEEP : ST_TIMER; // R1
				end
				ST_TIMER: begin
					if (mode_reg == MODE_SLEEP) begin
						state_reg <= ST_SLEEP; // R10
					end else if (cycle_ms_reg >= period_ms) begin
						state_reg <= ST_START; // R4
					end
				end
				ST_SLEEP: begin
					if (mode_reg != MODE_SLEEP) begin
						state_reg <= ST_START; // R10
					end
				end
				default: begin
					state_reg <= ST_START;
				end
			endcase
		end
	end

	assign sense_req = (state_reg == ST_REQ) && !idx_reg[3];
	assign sense_idx = idx_reg[2:0];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				count_mem[i] <= '0;
			end
		end else if (ce && state_reg == ST_WAIT && sense_done) begin
			count_mem[idx_reg[2:0]] <= sense_count;
		end
	end

	// period is measured from the start of sensing
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cycle_ms_reg <= '0;
		end else if (ce) begin
			if (state_reg == ST_START || state_reg == ST_SLEEP) begin
				cycle_ms_reg <= '0;
			end else if (ms_tick && cycle_ms_reg != 16'hFFFF) begin
				cycle_ms_reg <= cycle_ms_reg + 16'h0001; // R4
			end
		end
	end

	// host-visible status and latched pin controls change only here
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			button_status <= 8'h00;
			gpi_status    <= 8'h00;
			level_reg     <= 8'h00;
			width_reg     <= '0;
		end else if (ce && state_reg == ST_PROC) begin
			button_status <= touch_next; // R3 R6
			gpi_status    <= gpio_in & input_pins; // R6
			level_reg     <= host_level; // R18 R6
			width_reg     <= direct_width; // R19 R6
		end
	end

	// a new event in the same cycle as the host read keeps the line low
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_pend_reg <= 1'b0;
		end else if (ce) begin
			if (state_reg == ST_PROC && status_change) begin
				irq_pend_reg <= 1'b1; // R7 R6
			end else if (status_read) begin
				irq_pend_reg <= 1'b0;
			end
		end
	end
	assign host_irq_n = ~irq_pend_reg; // R7

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			idle_ms_reg <= '0;
		end else if (ce) begin
			if (|button_status || mode_reg != MODE_ACTIVE) begin
				idle_ms_reg <= '0;
			end else if (ms_tick && idle_ms_reg != 16'hFFFF) begin
				idle_ms_reg <= idle_ms_reg + 16'h0001; // R12
			end
		end
	end

	// host force has the last word in its cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mode_reg <= MODE_ACTIVE;
		end else if (ce) begin
			if (force_valid) begin
				case (force_mode)
					FORCE_DOZE:  mode_reg <= MODE_DOZE; // R14
					FORCE_SLEEP: mode_reg <= MODE_SLEEP; // R14
					default:     mode_reg <= MODE_ACTIVE; // R14
				endcase
			end else if (mode_reg == MODE_SLEEP) begin
				if (host_access || (state_reg == ST_SLEEP && gpi_wake)) begin
					mode_reg <= MODE_ACTIVE; // R11
				end
			end else if (mode_reg == MODE_DOZE) begin
				if (state_reg == ST_PROC && |touch_next) begin
					mode_reg <= MODE_ACTIVE; // R13
				end
			end else if (passive_ms != 16'h0000 && idle_ms_reg >= passive_ms) begin
				mode_reg <= MODE_DOZE; // R12
			end
		end
	end

	assign op_mode    = mode_reg;
	assign scan_phase = {state_reg == ST_TIMER || state_reg == ST_SLEEP,
		state_reg == ST_PROC, state_reg == ST_START || state_reg == ST_REQ
		|| state_reg == ST_WAIT};
	assign low_power  = (state_reg == ST_TIMER) || (state_reg == ST_SLEEP); // R4 R10

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fade_cnt_reg <= 8'h00;
		end else if (ce && ms_tick) begin
			fade_cnt_reg <= fade_tick ? 8'h00 : fade_cnt_reg + 8'h01;
		end
	end
	assign fade_tick = ms_tick && (fade_cnt_reg + 8'h01 >= fade_step_ms);

	// lowest touched button wins the analog level, else the idle level
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			first_duty_reg  <= 8'h00;
			second_duty_reg <= 8'h00;
		end else if (ce) begin
			first_duty_reg  <= level_idle;
			second_duty_reg <= level_idle;
			for (int i = NUM_PINS - 1; i >= 0; i--) begin
				if (button_status[i] && !level_to_second[i]) begin
					first_duty_reg <= level_width[8*i +: 8]; // R21
				end
			end
			for (int i = NUM_PINS - 1; i >= 0; i--) begin
				if (button_status[i] && level_to_second[i]) begin
					second_duty_reg <= level_width[8*i +: 8]; // R21
				end
			end
		end
	end

	// only a fresh touch starts the tone, so a held button stays silent
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			buzz_run_reg    <= 1'b0;
			buzz_phase2_reg <= 1'b0;
			buzz_cnt_reg    <= '0;
			buzz_half_reg   <= '0;
			buzz_sq_reg     <= 1'b0;
		end else if (ce) begin
			if (state_reg == ST_PROC && buzz_en && |(touch_next & ~button_status)) begin
				buzz_run_reg    <= 1'b1; // R22 R24
				buzz_phase2_reg <= 1'b0;
				buzz_cnt_reg    <= '0;
				buzz_half_reg   <= '0;
				buzz_sq_reg     <= ~buzz_idle;
			end else if (buzz_run_reg) begin
				if (buzz_cnt_reg == 24'(BUZZ_PHASE - 1)) begin
					buzz_cnt_reg    <= '0;
					buzz_phase2_reg <= 1'b1;
					buzz_run_reg    <= ~buzz_phase2_reg; // R22
				end else begin
					buzz_cnt_reg <= buzz_cnt_reg + 24'h000001;
				end
				if (buzz_half_reg >= (buzz_phase2_reg ? 16'(BUZZ_HALF2 - 1)
				    : 16'(BUZZ_HALF1 - 1))) begin
					buzz_half_reg <= '0;
					buzz_sq_reg   <= ~buzz_sq_reg;
				end else begin
					buzz_half_reg <= buzz_half_reg + 16'h0001;
				end
			end else begin
				buzz_sq_reg <= buzz_idle;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin
			logic [7:0] fade_duty;
			logic [7:0] pwm_duty;
			logic       pwm_q;
			logic [1:0] role;

			assign role = pin_role(pin_mode, g);

			fade_ramp u_fade (
				.ref_clk   (ref_clk),
				.srst      (srst),
				.ce        (ce),
				.step      (fade_tick),
				.on        (auto_light_en ? button_status[g] : level_reg[g]), // R17 R18
				.log_curve (fade_log),
				.lo_level  (fade_lo),
				.hi_level  (fade_hi),
				.duty      (fade_duty)
			);

			always_comb begin
				case (role)
					PIN_DIRECT:  pwm_duty = width_reg[8*g +: 8]; // R19
					PIN_SPECIAL: pwm_duty = (g == LEVEL_FIRST_PIN) ? first_duty_reg
						: second_duty_reg; // R21
					default:     pwm_duty = fade_duty; // R16
				endcase
			end

			pwm_gen #(
				.WIDTH (8)
			) u_pwm (
				.ref_clk (ref_clk),
				.srst    (srst),
				.ce      (ce),
				.duty    (pwm_duty),
				.pwm_out (pwm_q)
			); // R15

			always_ff @(posedge ref_clk) begin
				if (srst) begin
					gpio_out[g] <= 1'b0;
					gpio_oe[g]  <= 1'b0;
				end else if (ce) begin
					gpio_oe[g] <= (role != PIN_INPUT); // R20
					case (role)
						PIN_INPUT: gpio_out[g] <= 1'b0;
						PIN_SPECIAL: begin
							if (g == BUZZ_PIN) begin
								gpio_out[g] <= buzz_sq_reg; // R22
							end else if (g == LEVEL_FIRST_PIN || g == LEVEL_SECOND_PIN) begin
								gpio_out[g] <= pwm_q; // R21
							end else begin
								gpio_out[g] <= 1'b0; // R20
							end
						end
						default: gpio_out[g] <= pwm_q;
					endcase
				end
			end
		end
	endgenerate
endmodule

// ### touch_scan_pkg.sv
// constants and types shared by the touch scan controller files
// Notes on behaviour
// R1 - each scan cycle runs sensing, then processing, then low-power timer, then repeats
// R2 - sensing measures enabled inputs in ascending order first to last, skipping disabled ones
// R3 - processing evaluates results, then updates pin states and host-visible status
// R4 - timer phase idles in low power until the scan period expires
// R5 - host sets active and doze scan periods separately, 15 ms up to seconds
// R6 - pins, status and interrupt change only in processing; later changes wait a period
// R7 - interrupt line asserts while new touch or release information awaits the host
// R8 - active mode scans all enabled sensors with a short period, typically 30 ms
// R9 - doze mode uses a longer period, typically 195 ms, to save power
// R10 - sleep mode stops scanning; only host access and input-pin logic stay alive
// R11 - sleep ends on a host access or a change on an input-mode pin
// R12 - no touch for the passive-timer time moves active to doze; zero disables it
// R13 - a touch in doze returns the device to active mode
// R14 - host may force active, doze or sleep mode and the device obeys
// R15 - each of the eight pins owns an independent 256-step pwm generator
// R16 - fading mode ramps duty up on activation, down on release, linear or log
// R17 - with auto-lighting on, a touch fades in the pin mapped to that sensor
// R18 - with auto-lighting off, the host output level starts and stops the fade
// R19 - direct pulse mode drives the pin with the host pulse width, no fading
// R20 - each pin may be a plain input or a special buzzer or analog-level output; a special role on the first five pins drives low
// R21 - analog-level outputs sit on the eighth and seventh pins; duty names the button
// R22 - the buzzer sounds on the sixth pin for about 30 ms per touch
// R23 - touched at threshold plus hysteresis, released below threshold minus hysteresis
// R24 - the buzzer sounds once per touch and never repeats while held
package touch_scan_pkg;
	localparam int REF_CLK_HZ        = 10_000_000;
	localparam int MS_CYCLES         = REF_CLK_HZ / 1000;
	localparam int SCAN_MIN_MS       = 15;
	localparam int ACTIVE_PERIOD_MS  = 30;
	localparam int DOZE_PERIOD_MS    = 195;
	localparam int BUZZ_PHASE_MS     = 15;
	localparam int BUZZ_PHASE_CYCLES = BUZZ_PHASE_MS * MS_CYCLES;
	localparam int BUZZ_TONE1_HZ     = 4000;
	localparam int BUZZ_TONE2_HZ     = 8000;
	localparam int BUZZ_HALF1_CYCLES = REF_CLK_HZ / (2 * BUZZ_TONE1_HZ);
	localparam int BUZZ_HALF2_CYCLES = REF_CLK_HZ / (2 * BUZZ_TONE2_HZ);
	localparam int NUM_PINS          = 8;
	localparam int COUNT_W           = 10;
	localparam int BUZZ_PIN          = 5;
	localparam int LEVEL_SECOND_PIN  = 6;
	localparam int LEVEL_FIRST_PIN   = 7;
	localparam logic [1:0] PIN_FADING  = 2'h0;
	localparam logic [1:0] PIN_DIRECT  = 2'h1;
	localparam logic [1:0] PIN_INPUT   = 2'h2;
	localparam logic [1:0] PIN_SPECIAL = 2'h3;
	localparam logic [1:0] FORCE_ACTIVE = 2'h0;
	localparam logic [1:0] FORCE_DOZE   = 2'h1;
	localparam logic [1:0] FORCE_SLEEP  = 2'h2;
	typedef enum logic [5:0] {
		ST_START = 6'h01,
		ST_REQ   = 6'h02,
		ST_WAIT  = 6'h04,
		ST_PROC  = 6'h08,
		ST_TIMER = 6'h10,
		ST_SLEEP = 6'h20
	} scan_state_e;
	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'h1,
		MODE_DOZE   = 3'h2,
		MODE_SLEEP  = 3'h4
	} op_mode_e;
endpackage

// ### pwm_gen.sv
// one 256-step pulse width generator
`timescale 1ns/1ps
module pwm_gen
	import touch_scan_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] duty,
	output logic                  pwm_out
);
	logic [WIDTH-1:0] cnt_reg;

	generate
		if (WIDTH < 2) begin : g_chk
			$error("pwm_gen needs at least two bits");
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_reg <= '0;
		end else if (ce) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// duty 0 stays low for a whole period
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pwm_out <= 1'b0;
		end else if (ce) begin
			pwm_out <= (cnt_reg < duty);
		end
	end
endmodule

// ### fade_ramp.sv
// duty ramp for one fading pin
`timescale 1ns/1ps
module fade_ramp
	import touch_scan_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic       step,
	input  wire logic       on,
	input  wire logic       log_curve,
	input  wire logic [7:0] lo_level,
	input  wire logic [7:0] hi_level,
	output logic      [7:0] duty
);
	logic [7:0] inc;
	logic [8:0] up_sum;

	// log curve grows the step with the level so brightness looks even
	assign inc    = log_curve ? (8'(duty >> 3) + 8'h01) : 8'h01;
	assign up_sum = {1'b0, duty} + {1'b0, inc};

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			duty <= 8'h00;
		end else if (ce && step) begin
			if (on) begin
				duty <= (up_sum >= {1'b0, hi_level}) ? hi_level : up_sum[7:0]; // R16
			end else if (duty <= lo_level || duty - lo_level <= inc) begin
				duty <= lo_level;
			end else begin
				duty <= duty - inc; // R16
			end
		end
	end
endmodule

// ### sense_frontend_model.sv
// behavioural charge count front end answering the scan sequencer
`timescale 1ns/1ps
module sense_frontend_model
	import touch_scan_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 sense_req,
	input  wire logic [2:0]           sense_idx,
	input  wire logic [8*COUNT_W-1:0] counts,
	output logic                      sense_done,
	output logic      [COUNT_W-1:0]   sense_count
);
	logic [2:0] idx;
	initial begin
		sense_done = 1'h0;
		sense_count = '0;
		forever begin
			@(negedge ref_clk);
			if (sense_req) begin
				idx = sense_idx;
				// odd sensors answer slowly so the wait state is held for several cycles
				repeat (idx[0] ? 5 : 1) @(posedge ref_clk);
				sense_done <= 1'h1;
				sense_count <= counts[idx*COUNT_W +: COUNT_W];
				@(posedge ref_clk);
				sense_done <= 1'h0;
				// count is only valid with done, so show a wrong value afterwards
				sense_count <= ~counts[idx*COUNT_W +: COUNT_W];
			end
		end
	end
endmodule

// ### touch_scan_mode_controller_sva.sv
// port assertions for the touch scan mode controller
`timescale 1ns/1ps
module touch_scan_mode_controller_chk
	import touch_scan_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       srst,
	input wire logic [7:0] sense_enable,
	input wire logic       sense_req,
	input wire logic [2:0] sense_idx,
	input wire logic       force_valid,
	input wire logic [1:0] force_mode,
	input wire logic       host_access,
	input wire logic       status_read,
	input wire logic       host_irq_n,
	input wire logic [7:0] button_status,
	input wire logic [2:0] op_mode,
	input wire logic [2:0] scan_phase
);
	logic [2:0] exp_mode;
	logic       first_reg;
	logic [2:0] last_idx_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	assign exp_mode = (force_mode == FORCE_DOZE) ? 3'h2 : (force_mode == FORCE_SLEEP) ? 3'h4 : 3'h1;
	// a new scan restarts the ascending order check
	always_ff @(posedge ref_clk) begin
		if (srst || scan_phase[1])
			first_reg <= 1'h1;
		else if (sense_req)
			first_reg <= 1'h0;
	end
	always_ff @(posedge ref_clk) begin
		if (sense_req)
			last_idx_reg <= sense_idx;
	end
	AST_REQ_ONE: assert property (sense_req |=> !sense_req)
		else $error("sense request held past one cycle");
	AST_REQ_ENABLED: assert property (sense_req |-> sense_enable[sense_idx])
		else $error("disabled sensor measured");
	AST_IDX_ASC: assert property (sense_req && !first_reg |-> sense_idx > last_idx_reg)
		else $error("sensor order not ascending");
	AST_PROC_TO_WAIT: assert property (scan_phase[1] |=> scan_phase == 3'h4)
		else $error("processing not followed by low power");
	AST_SENSE_AFTER_WAIT: assert property ($rose(scan_phase[0]) |-> $past(scan_phase[2]))
		else $error("sensing started outside low power");
	AST_BUTTON_AT_PROC: assert property (!$stable(button_status) |-> $past(scan_phase[1]))
		else $error("button status changed outside processing");
	AST_IRQ_AT_PROC: assert property ($fell(host_irq_n) |-> $past(scan_phase[1]))
		else $error("interrupt raised outside processing");
	AST_IRQ_HOLD: assert property (!host_irq_n && !status_read |=> !host_irq_n)
		else $error("interrupt dropped without a status read");
	AST_IRQ_CLEAR: assert property (!host_irq_n && status_read && !scan_phase[1] |=> host_irq_n)
		else $error("status read did not clear interrupt");
	AST_FORCE: assert property (force_valid |=> op_mode == $past(exp_mode))
		else $error("forced mode not taken");
	AST_WAKE: assert property (host_access && op_mode == 3'h4 && scan_phase == 3'h4 |=> op_mode == 3'h1)
		else $error("host access did not wake");
	cover property (force_valid && force_mode == FORCE_SLEEP);
	cover property ($fell(host_irq_n));
	cover property (host_access && op_mode == 3'h4);
	cover property (op_mode == 3'h2 ##1 op_mode == 3'h1);
endmodule
bind touch_scan_mode_controller touch_scan_mode_controller_chk u_touch_scan_mode_controller_chk (.*);

// ### tb.sv
// self-checking testbench for the touch scan mode controller
`timescale 1ns/1ps
module tb
	import touch_scan_pkg::*;
;
	logic                 ref_clk = 1'h0;
	logic                 srst, ce, force_valid, host_access, status_read, auto_light_en;
	logic                 fade_log, buzz_en, buzz_idle, sense_req, sense_done, host_irq_n, low_power;
	logic [1:0]           force_mode;
	logic [2:0]           sense_idx, op_mode, scan_phase;
	logic [7:0]           sense_enable, host_level, fade_step_ms, fade_lo, fade_hi, level_idle;
	logic [7:0]           level_to_second, gpio_in, button_status, gpi_status, gpio_out, gpio_oe;
	logic [COUNT_W-1:0]   sense_count, threshold, hysteresis;
	logic [15:0]          active_period_ms, doze_period_ms, passive_ms, pin_mode;
	logic [63:0]          direct_width, level_width;
	logic [8*COUNT_W-1:0] counts;
	logic [2:0]           order[$];
	int                   n_fail, samples_checked, cyc, gap, t0, k, t;
	bit                   p0;
	touch_scan_mode_controller #(.MS_CYC(10), .BUZZ_PHASE(50), .BUZZ_HALF1(4), .BUZZ_HALF2(2))
		u_touch_scan_mode_controller (.*);
	sense_frontend_model u_sense_frontend_model (.*);
	initial forever #50 ref_clk = ~ref_clk;
	always @(negedge ref_clk) begin
		cyc++;
		if (sense_req)
			order.push_back(sense_idx);
		if (scan_phase[0] && !p0) begin
			gap = cyc - t0;
			t0 = cyc;
		end
		p0 = scan_phase[0];
	end
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic scans(input int n);
		int w;
		repeat (n) begin
			w = 0;
			while (scan_phase[1] !== 1'h1 && w < 5000) begin
				@(negedge ref_clk);
				w++;
			end
			chk(w < 5000, 1'h1, "processing phase reached");
			@(negedge ref_clk);
		end
	endtask
	task automatic hcount(input int pin, input int exp, input string what);
		int h;
		h = 0;
		repeat (256) begin
			@(negedge ref_clk);
			h += gpio_out[pin];
		end
		chk(h, exp, what);
	endtask
	task automatic put(input int b, input logic [COUNT_W-1:0] v);
		@(posedge ref_clk);
		counts[b*COUNT_W +: COUNT_W] <= v;
	endtask
	task automatic toggles(output int n);
		logic v;
		n = 0;
		v = gpio_out[BUZZ_PIN];
		repeat (130) begin
			@(negedge ref_clk);
			n += (gpio_out[BUZZ_PIN] !== v);
			v = gpio_out[BUZZ_PIN];
		end
	endtask
	task automatic force_to(input logic [1:0] m, input logic [2:0] exp);
		@(posedge ref_clk);
		force_valid <= 1'h1;
		force_mode <= m;
		@(posedge ref_clk);
		force_valid <= 1'h0;
		@(negedge ref_clk);
		chk(op_mode, exp, "forced mode");
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_fail++;
		summarize();
	end
	initial begin
		srst = 1'h1;
		ce = 1'h1;
		sense_enable = 8'hA5;
		threshold = 10'h100;
		hysteresis = 10'h020;
		active_period_ms = 16'h0014;
		doze_period_ms = 16'h0028;
		passive_ms = 16'h0000;
		force_valid = 1'h0;
		force_mode = 2'h0;
		host_access = 1'h0;
		status_read = 1'h0;
		pin_mode = 16'hFEA4;
		auto_light_en = 1'h1;
		host_level = 8'h00;
		direct_width = 64'h0000_0000_0000_4000;
		level_width = 64'h0000_0000_0080_0000;
		level_idle = 8'h10;
		fade_log = 1'h0;
		fade_step_ms = 8'h01;
		fade_lo = 8'h00;
		fade_hi = 8'h08;
		level_to_second = 8'h00;
		buzz_en = 1'h1;
		buzz_idle = 1'h0;
		gpio_in = 8'h00;
		counts = {8{10'h010}};
		repeat (10) @(posedge ref_clk);
		srst <= 1'h0;
		@(negedge ref_clk);
		chk({host_irq_n, op_mode, scan_phase}, 7'h49, "reset outputs");
		scans(2);
		order.delete();
		scans(1);
		chk(order.size(), 4, "sensors measured");
		k = 0;
		for (int i = 0; i < 8; i++) begin
			if (sense_enable[i]) begin
				chk(order[k], i, "sensing order");
				k++;
			end
		end
		chk(gap >= 185 && gap <= 205, 1'h1, "active scan period");
		@(posedge ref_clk);
		active_period_ms <= 16'h0005;
		sense_enable <= 8'hFF;
		scans(3);
		chk(gap >= 135 && gap <= 155, 1'h1, "minimum scan period");
		put(0, 10'h120);
		put(1, 10'h11F);
		scans(1);
		chk({host_irq_n, button_status}, 9'h001, "touch at threshold plus hysteresis");
		@(posedge ref_clk);
		status_read <= 1'h1;
		@(posedge ref_clk);
		status_read <= 1'h0;
		put(0, 10'h0E0);
		scans(1);
		chk({host_irq_n, button_status}, 9'h101, "still touched, no new report");
		put(0, 10'h0DF);
		scans(1);
		chk({host_irq_n, button_status}, 9'h000, "release below threshold");
		put(2, 10'h200);
		scans(1);
		toggles(t);
		chk(t >= 33 && t <= 40, 1'h1, "buzzer tone edges");
		scans(1);
		toggles(t);
		chk({t[3:0], gpio_out[BUZZ_PIN]}, {4'h0, buzz_idle}, "held touch is silent");
		hcount(LEVEL_FIRST_PIN, 128, "first analog level");
		hcount(1, 64, "direct pulse width");
		chk(gpio_oe & 8'h1F, 8'h03, "input pins released");
		@(posedge ref_clk);
		level_to_second <= 8'h04;
		scans(2);
		hcount(LEVEL_SECOND_PIN, 128, "second analog level");
		hcount(LEVEL_FIRST_PIN, 16, "first analog idle");
		put(2, 10'h010);
		put(0, 10'h200);
		scans(1);
		repeat (200) @(negedge ref_clk);
		hcount(0, 8, "auto-light fade in");
		put(0, 10'h010);
		scans(1);
		repeat (200) @(negedge ref_clk);
		hcount(0, 0, "fade out on release");
		@(posedge ref_clk);
		auto_light_en <= 1'h0;
		fade_log <= 1'h1;
		host_level <= 8'h01;
		scans(1);
		repeat (200) @(negedge ref_clk);
		hcount(0, 8, "host started fade");
		@(posedge ref_clk);
		passive_ms <= 16'h0028;
		k = 0;
		while (op_mode !== 3'h2 && k < 2000) begin
			@(negedge ref_clk);
			k++;
		end
		chk(op_mode, 3'h2, "passive timer to doze");
		scans(3);
		chk(gap >= 385 && gap <= 405, 1'h1, "doze scan period");
		put(4, 10'h200);
		scans(1);
		chk(op_mode, 3'h1, "touch leaves doze");
		@(posedge ref_clk);
		passive_ms <= 16'h0000;
		for (int m = 0; m < 4; m++)
			force_to(2'(m), (m == 1) ? 3'h2 : (m == 2) ? 3'h4 : 3'h1);
		force_to(FORCE_SLEEP, 3'h4);
		repeat (400) @(negedge ref_clk);
		order.delete();
		repeat (400) @(negedge ref_clk);
		chk({scan_phase, low_power, 12'(order.size())}, {3'h4, 1'h1, 12'h0}, "no scan in sleep");
		@(posedge ref_clk);
		host_access <= 1'h1;
		@(posedge ref_clk);
		host_access <= 1'h0;
		@(negedge ref_clk);
		chk(op_mode, 3'h1, "host access wakes");
		force_to(FORCE_SLEEP, 3'h4);
		repeat (400) @(negedge ref_clk);
		@(posedge ref_clk);
		gpio_in <= 8'h08;
		repeat (5) @(negedge ref_clk);
		chk(op_mode, 3'h1, "input pin wakes");
		scans(1);
		chk(gpi_status, 8'h08, "input pin sampled");
		summarize();
	end
endmodule
